// ---- design/mah_pkg.sv ----
// Constants, types and field layout for the address, hash and PHY block
//
// Contract
// RQ1 - Low station address register holds address bits 31:0, host read/write.
// RQ2 - At power-on, load low address from programmed configuration memory.
// RQ3 - Memory locations 0x01..0x04 fill low address bytes 7:0 up to 31:24.
// RQ4 - Wire order: low bytes 7:0 first through 31:24, then high bytes.
// RQ5 - Host writes to low address take effect only after the load completes.
// RQ6 - Leftmost written address byte is most significant and goes first.
// RQ7 - Six-bit hash index: top bit picks half, five bits pick the bit.
// RQ8 - Index 00000 selects low bit 0; 11111 selects high bit 31.
// RQ9 - Multicast accepted when selected hash bit is one, else rejected.
// RQ10 - Pass-all-multicast bit accepts every multicast frame.
// RQ11 - High hash holds bits 63:32, low 31:0; both read/write, reset zero.
// RQ12 - Access register bits 15-11 carry PHY address; internal PHY is 00001b.
// RQ13 - Access register bits 10-6 select the register inside the PHY.
// RQ14 - Access bit 1 set writes data register to PHY; clear reads into it.
// RQ15 - Software sets busy bit 0; device clears it when the access completes.
// RQ16 - Host polls busy low before writing access or data registers.
// RQ17 - Host keeps data register unchanged during a PHY write.
// RQ18 - On a read, returned value lands in data register before busy clears.
// RQ19 - Data register bits 15-0 hold the PHY value; upper bits reserved.
// RQ20 - Management cycle goes out as a clause 22 serial frame on MDC/MDIO.
// RQ21 - Reserved access and data bits read zero and ignore writes.
package mah_pkg;

  // Register indices, byte address is four times the index
  localparam int IDX_STATION_ADDR_LOW = 3;
  localparam int IDX_GROUP_HASH_HIGH = 4;
  localparam int IDX_GROUP_HASH_LOW = 5;
  localparam int IDX_PHY_MGMT_ACCESS = 6;
  localparam int IDX_PHY_MGMT_DATA = 7;
  localparam int IDX_FILTER_CTRL = 16;
  localparam logic [11:0] OFS_STATION_ADDR_LOW = 12'(4 * IDX_STATION_ADDR_LOW);
  localparam logic [11:0] OFS_GROUP_HASH_HIGH = 12'(4 * IDX_GROUP_HASH_HIGH);
  localparam logic [11:0] OFS_GROUP_HASH_LOW = 12'(4 * IDX_GROUP_HASH_LOW);
  localparam logic [11:0] OFS_PHY_MGMT_ACCESS = 12'(4 * IDX_PHY_MGMT_ACCESS);
  localparam logic [11:0] OFS_PHY_MGMT_DATA = 12'(4 * IDX_PHY_MGMT_DATA);
  localparam logic [11:0] OFS_FILTER_CTRL = 12'(4 * IDX_FILTER_CTRL);

  // Reset values
  localparam logic [31:0] RST_STATION_ADDR_LOW = 32'h0FFF_FFFF;
  localparam logic [31:0] RST_GROUP_HASH = 32'h0000_0000;
  localparam logic [31:0] RST_PHY_MGMT = 32'h0000_0000;

  // Field positions
  localparam int ACC_PHY_ADDR_MSB = 15;
  localparam int ACC_PHY_ADDR_LSB = 11;
  localparam int ACC_REG_IDX_MSB = 10;
  localparam int ACC_REG_IDX_LSB = 6;
  localparam int ACC_WRITE_BIT = 1;
  localparam int ACC_BUSY_BIT = 0;
  localparam int DATA_MSB = 15;
  localparam int FCTL_PASS_ALL_BIT = 0;
  localparam int FCTL_LOAD_DONE_BIT = 1;

  // Configuration memory locations of the low address bytes
  localparam logic [7:0] CFG_ADDR_FIRST = 8'h01;
  localparam logic [7:0] CFG_ADDR_LAST = 8'h04;

  // Management clock timing at the 100 MHz core clock
  localparam int CLK_PERIOD_NS = 10;
  localparam int MDC_HALF_MIN_NS = 200;
  localparam int MDC_HALF_CYC =
    (MDC_HALF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Clause 22 frame layout, bit 0 is the first bit on the wire
  localparam int MDIO_FRAME_BITS = 64;
  localparam int MDIO_TA_BIT = 46;
  localparam int MDIO_DATA_BIT = 48;
  localparam logic [31:0] MDIO_PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [1:0] MDIO_START = 2'h1;
  localparam logic [1:0] MDIO_OP_WRITE = 2'h1;
  localparam logic [1:0] MDIO_OP_READ = 2'h2;
  localparam logic [1:0] MDIO_TA_WRITE = 2'h2;

  // Management command handed to the serial engine
  typedef struct packed {
    logic write;
    logic [4:0] phyAddr;
    logic [4:0] regIdx;
    logic [15:0] data;
  } mah_mgmt_cmd_t;

  // Destination address offered to the group filter
  typedef struct packed {
    logic valid;
    logic [47:0] destAddr;
  } mah_filt_req_t;

  // Group filter verdict
  typedef struct packed {
    logic done;
    logic multicast;
    logic accept;
    logic [5:0] index;
  } mah_filt_rsp_t;

endpackage

// ---- design/mah_mdio_engine.sv ----
// Clause 22 serial management frame generator
`timescale 1ns/1ps
module mah_mdio_engine #(
  parameter int HALF_CYC = mah_pkg::MDC_HALF_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Command side
  input wire logic start,
  input mah_pkg::mah_mgmt_cmd_t cmd,
  output logic done,
  output logic [15:0] rdData,
  // Management pins
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe
);
  import mah_pkg::*;

  logic active_q;
  logic [7:0] divCnt_q;
  logic [5:0] bitCnt_q;
  logic [MDIO_FRAME_BITS-1:0] shift_q;
  logic [MDIO_FRAME_BITS-1:0] frame;
  logic [5:0] nextBit;

  // Whole frame built up front, first wire bit at the top
  assign frame = {MDIO_PREAMBLE, MDIO_START,
                  cmd.write ? MDIO_OP_WRITE : MDIO_OP_READ,
                  cmd.phyAddr, cmd.regIdx,
                  cmd.write ? MDIO_TA_WRITE : 2'h0, cmd.data};
  assign nextBit = bitCnt_q + 6'h1;

  // Drive on MDC fall, sample on MDC rise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      active_q <= 1'b0;
      divCnt_q <= 8'h00;
      bitCnt_q <= 6'h00;
      shift_q <= '0;
      mdc <= 1'b0;
      mdioOut <= 1'b0;
      mdioOe <= 1'b0;
      done <= 1'b0;
      rdData <= 16'h0000;
    end else begin
      done <= 1'b0;
      if (!active_q) begin
        if (start) begin // RQ20
          active_q <= 1'b1;
          divCnt_q <= 8'h00;
          bitCnt_q <= 6'h00;
          shift_q <= frame;
          mdc <= 1'b0;
          mdioOut <= frame[MDIO_FRAME_BITS-1];
          mdioOe <= 1'b1;
        end
      end else if (divCnt_q == 8'(HALF_CYC - 1)) begin
        divCnt_q <= 8'h00;
        if (!mdc) begin
          mdc <= 1'b1;
          // Read data shifts in MSB first
          if (bitCnt_q >= 6'(MDIO_DATA_BIT)) begin
            rdData <= {rdData[14:0], mdioIn};
          end
        end else begin
          mdc <= 1'b0;
          if (bitCnt_q == 6'(MDIO_FRAME_BITS - 1)) begin
            active_q <= 1'b0;
            mdioOe <= 1'b0;
            done <= 1'b1;
          end else begin
            bitCnt_q <= nextBit;
            shift_q <= {shift_q[MDIO_FRAME_BITS-2:0], 1'b0};
            mdioOut <= shift_q[MDIO_FRAME_BITS-2];
            // PHY owns the line from turnaround on a read
            mdioOe <= cmd.write | (nextBit < 6'(MDIO_TA_BIT));
          end
        end
      end else begin
        divCnt_q <= divCnt_q + 8'h01;
      end
    end
  end

endmodule

// ---- design/mah_hash_filter.sv ----
// Group address hash lookup against the 64-bit table
`timescale 1ns/1ps
module mah_hash_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Lookup request and table
  input mah_pkg::mah_filt_req_t req,
  input wire logic [63:0] hashTable,
  input wire logic passAll,
  // Verdict
  output mah_pkg::mah_filt_rsp_t rsp
);
  import mah_pkg::*;

  logic [5:0] index;
  logic hit;

  // CRC-32 over the address in wire order, index from its top bits
  function automatic logic [5:0] hash_index(input logic [47:0] da);
    logic [31:0] crc;
    crc = 32'hFFFF_FFFF;
    for (int b = 0; b < 6; b++) begin
      for (int i = 0; i < 8; i++) begin
        // First byte on the wire is the leftmost, LSB first
        crc = {crc[30:0], 1'b0} ^
              ({32{crc[31] ^ da[40 - 8 * b + i]}} & 32'h04C1_1DB7);
      end
    end
    return crc[31:26];
  endfunction

  assign index = hash_index(req.destAddr); // RQ7
  assign hit = hashTable[index]; // RQ8

  // Verdict registered one cycle after the request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rsp <= '0;
    end else begin
      rsp.done <= req.valid;
      rsp.multicast <= req.destAddr[40];
      rsp.accept <= req.destAddr[40] & (passAll | hit); // RQ9 RQ10
      rsp.index <= index;
    end
  end

endmodule

// ---- design/mah_regs_top.sv ----
// Station address, group hash and PHY management registers on APB
`timescale 1ns/1ps
module mah_regs_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Configuration memory controller
  input wire logic cfgPresent,
  output logic cfgReq,
  output logic [7:0] cfgAddr,
  input wire logic cfgAck,
  input wire logic [7:0] cfgData,
  // Group address filter
  input mah_pkg::mah_filt_req_t filtReq,
  output mah_pkg::mah_filt_rsp_t filtRsp,
  // Management pins
  output logic mdc,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe
);
  import mah_pkg::*;

  typedef enum logic [1:0] {
    LD_CHECK,
    LD_FETCH,
    LD_WAIT,
    LD_DONE
  } mah_load_state_t;

  // Register state
  logic [31:0] stationAddrLow_q;
  logic [31:0] groupHashHigh_q;
  logic [31:0] groupHashLow_q;
  logic [4:0] phyAddr_q;
  logic [4:0] phyRegIndex_q;
  logic phyWriteSelect_q;
  logic phyAccessBusy_q;
  logic [15:0] phyData_q;
  logic acceptAllGroup_q;

  // Bus and engine handshake
  logic accessPhase;
  logic wrEn;
  logic [31:0] wrMask;
  logic [31:0] rdMux;
  logic decErr;
  logic selAddrLow;
  logic selHashHigh;
  logic selHashLow;
  logic selAccess;
  logic selData;
  logic selFctl;
  logic mgmtStart_q;
  logic mgmtDone;
  logic [15:0] mgmtRdData;
  mah_mgmt_cmd_t mgmtCmd;

  // Power-on load state
  mah_load_state_t loadState_q;
  logic loadDone;
  logic loadByte;
  logic [1:0] loadLane;

  // Byte strobes widened to a bit mask
  function automatic logic [31:0] strobe_mask(input logic [3:0] s);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[8 * i +: 8] = {8{s[i]}};
    end
    return m;
  endfunction

  // Address decode
  assign selAddrLow = (paddr == OFS_STATION_ADDR_LOW);
  assign selHashHigh = (paddr == OFS_GROUP_HASH_HIGH);
  assign selHashLow = (paddr == OFS_GROUP_HASH_LOW);
  assign selAccess = (paddr == OFS_PHY_MGMT_ACCESS);
  assign selData = (paddr == OFS_PHY_MGMT_DATA);
  assign selFctl = (paddr == OFS_FILTER_CTRL);
  assign decErr = ~(selAddrLow | selHashHigh | selHashLow |
                    selAccess | selData | selFctl);

  // A write lands only at the edge where pready is seen high
  assign accessPhase = psel & penable;
  assign wrEn = accessPhase & pready & pwrite & ~decErr;
  assign wrMask = strobe_mask(pstrb);

  // One wait state on every transfer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
    end else begin
      pready <= accessPhase & ~pready;
    end
  end

  // Error flag for unmapped addresses, with the answer
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= accessPhase & ~pready & decErr;
    end
  end

  // Read multiplexer, reserved bits as zero
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (1'b1)
      selAddrLow: rdMux = stationAddrLow_q; // RQ1
      selHashHigh: rdMux = groupHashHigh_q; // RQ11
      selHashLow: rdMux = groupHashLow_q; // RQ11
      selAccess: begin
        rdMux[ACC_PHY_ADDR_MSB:ACC_PHY_ADDR_LSB] = phyAddr_q; // RQ12
        rdMux[ACC_REG_IDX_MSB:ACC_REG_IDX_LSB] = phyRegIndex_q; // RQ13
        rdMux[ACC_WRITE_BIT] = phyWriteSelect_q; // RQ14
        rdMux[ACC_BUSY_BIT] = phyAccessBusy_q; // RQ15 RQ21
      end
      selData: rdMux[DATA_MSB:0] = phyData_q; // RQ19 RQ21
      selFctl: begin
        rdMux[FCTL_PASS_ALL_BIT] = acceptAllGroup_q;
        rdMux[FCTL_LOAD_DONE_BIT] = loadDone;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Read data captured as the answer is raised
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (accessPhase & ~pready & ~pwrite) begin
      prdata <= rdMux;
    end
  end

  // Power-on load sequencing
  assign loadDone = (loadState_q == LD_DONE);
  assign loadByte = (loadState_q == LD_WAIT) & cfgAck;
  assign loadLane = 2'(cfgAddr - CFG_ADDR_FIRST);

  // Walk locations 0x01..0x04 once, or skip if memory is blank
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      loadState_q <= LD_CHECK;
    end else begin
      unique case (loadState_q)
        LD_CHECK: begin
          loadState_q <= cfgPresent ? LD_FETCH : LD_DONE; // RQ2
        end
        LD_FETCH: begin
          loadState_q <= LD_WAIT;
        end
        LD_WAIT: begin
          if (cfgAck) begin
            loadState_q <= (cfgAddr == CFG_ADDR_LAST) ? LD_DONE : LD_FETCH;
          end
        end
        LD_DONE: begin
          loadState_q <= LD_DONE;
        end
      endcase
    end
  end

  // Request held until the controller acknowledges the byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfgReq <= 1'b0;
    end else if (loadState_q == LD_FETCH) begin
      cfgReq <= 1'b1;
    end else if (loadByte) begin
      cfgReq <= 1'b0;
    end
  end

  // Memory location steps from the first to the last address byte
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfgAddr <= CFG_ADDR_FIRST;
    end else if (loadByte && cfgAddr != CFG_ADDR_LAST) begin
      cfgAddr <= cfgAddr + 8'h01; // RQ3
    end
  end

  // Station address lanes, loaded byte or host strobe per lane
  for (genvar g = 0; g < 4; g++) begin : gAddrLane
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        stationAddrLow_q[8 * g +: 8] <= RST_STATION_ADDR_LOW[8 * g +: 8];
      end else if (loadByte && loadLane == 2'(g)) begin
        // Lane 0 is the first byte on the wire
        stationAddrLow_q[8 * g +: 8] <= cfgData; // RQ3 RQ4 RQ6
      end else if (wrEn && selAddrLow && pstrb[g] && loadDone) begin
        // Host writes before load completion are dropped
        stationAddrLow_q[8 * g +: 8] <= pwdata[8 * g +: 8]; // RQ1 RQ5
      end
    end
  end

  // Hash table halves
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      groupHashHigh_q <= RST_GROUP_HASH;
    end else if (wrEn && selHashHigh) begin
      groupHashHigh_q <= (groupHashHigh_q & ~wrMask) | // RQ11
                         (pwdata & wrMask);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      groupHashLow_q <= RST_GROUP_HASH;
    end else if (wrEn && selHashLow) begin
      groupHashLow_q <= (groupHashLow_q & ~wrMask) | // RQ11
                        (pwdata & wrMask);
    end
  end

  // Filter control, pass-all-multicast in bit 0
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acceptAllGroup_q <= 1'b0;
    end else if (wrEn && selFctl && pstrb[0]) begin
      acceptAllGroup_q <= pwdata[FCTL_PASS_ALL_BIT]; // RQ10
    end
  end

  // Access fields frozen while busy so the frame stays consistent
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phyAddr_q <= RST_PHY_MGMT[ACC_PHY_ADDR_MSB:ACC_PHY_ADDR_LSB];
      phyRegIndex_q <= RST_PHY_MGMT[ACC_REG_IDX_MSB:ACC_REG_IDX_LSB];
      phyWriteSelect_q <= RST_PHY_MGMT[ACC_WRITE_BIT];
    end else if (wrEn && selAccess && !phyAccessBusy_q) begin
      if (pstrb[1]) begin
        phyAddr_q <= pwdata[ACC_PHY_ADDR_MSB:ACC_PHY_ADDR_LSB]; // RQ12
      end
      if (pstrb[0] && pstrb[1]) begin
        phyRegIndex_q <= pwdata[ACC_REG_IDX_MSB:ACC_REG_IDX_LSB]; // RQ13
      end
      if (pstrb[0]) begin
        phyWriteSelect_q <= pwdata[ACC_WRITE_BIT]; // RQ14
      end
    end
  end

  // Busy set by software, cleared by the engine when the frame ends
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phyAccessBusy_q <= RST_PHY_MGMT[ACC_BUSY_BIT];
    end else if (mgmtDone) begin
      phyAccessBusy_q <= 1'b0; // RQ15
    end else if (wrEn && selAccess && pstrb[0] && !phyAccessBusy_q) begin
      phyAccessBusy_q <= pwdata[ACC_BUSY_BIT]; // RQ15 RQ16
    end
  end

  // Start pulse raised at the same edge as busy, one cycle wide
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mgmtStart_q <= 1'b0;
    end else begin
      mgmtStart_q <= wrEn & selAccess & pstrb[0] & ~phyAccessBusy_q &
                     pwdata[ACC_BUSY_BIT];
    end
  end

  // Data register, read result lands as busy clears
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phyData_q <= RST_PHY_MGMT[DATA_MSB:0];
    end else if (mgmtDone && !phyWriteSelect_q) begin
      phyData_q <= mgmtRdData; // RQ18
    end else if (wrEn && selData && !phyAccessBusy_q) begin
      // Protected while busy so a write frame sends stable data
      if (pstrb[0]) begin
        phyData_q[7:0] <= pwdata[7:0]; // RQ17 RQ19
      end
      if (pstrb[1]) begin
        phyData_q[15:8] <= pwdata[15:8]; // RQ19
      end
    end
  end

  // Command to the serial engine, fields stable while busy
  assign mgmtCmd = '{write: phyWriteSelect_q,
                     phyAddr: phyAddr_q,
                     regIdx: phyRegIndex_q,
                     data: phyData_q};

  // Serial management engine
  mah_mdio_engine #(
    .HALF_CYC(MDC_HALF_CYC)
  ) uMdio (
    .clk(clk),
    .reset(reset),
    .start(mgmtStart_q),
    .cmd(mgmtCmd),
    .done(mgmtDone),
    .rdData(mgmtRdData),
    .mdc(mdc),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe)
  );

  // Group filter lookup against both hash halves
  mah_hash_filter uHash (
    .clk(clk),
    .reset(reset),
    .req(filtReq),
    .hashTable({groupHashHigh_q, groupHashLow_q}),
    .passAll(acceptAllGroup_q),
    .rsp(filtRsp)
  );

endmodule

// ---- verif/mah_regs_sva.sv ----
// Checker for the address, hash and PHY register block ports
`timescale 1ns/1ps
module mah_regs_sva (
  // Clock and reset
  input logic clk,
  input logic reset,
  // APB slave
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Configuration memory
  input logic cfgPresent,
  input logic cfgReq,
  input logic [7:0] cfgAddr,
  input logic cfgAck,
  input logic [7:0] cfgData,
  // Group filter
  input mah_pkg::mah_filt_req_t filtReq,
  input mah_pkg::mah_filt_rsp_t filtRsp,
  // Management pins
  input logic mdc,
  input logic mdioIn,
  input logic mdioOut,
  input logic mdioOe
);
  import mah_pkg::*;
  default clocking dc @(posedge clk); endclocking
  default disable iff (reset);
  logic [7:0] hiCnt_q;
  // Length of the current management clock high phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hiCnt_q <= 8'h00;
    end else begin
      hiCnt_q <= mdc ? hiCnt_q + 8'h01 : 8'h00;
    end
  end
  property p_rdy_lat;
    psel && penable && !$past(penable) |=> pready;
  endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("late ready");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("long ready");
  property p_mdc_start;
    psel && penable && pready && pwrite && pstrb[0] &&
      paddr == OFS_PHY_MGMT_ACCESS && pwdata[ACC_BUSY_BIT] |-> ##[1:60] mdc;
  endproperty
  a_mdc_start: assert property (p_mdc_start) else $error("no frame");
  property p_mdc_high;
    $fell(mdc) |-> hiCnt_q == 8'(MDC_HALF_CYC);
  endproperty
  a_mdc_high: assert property (p_mdc_high) else $error("mdc width");
  property p_mdio_edge;
    mdioOe && $past(mdioOe) && $changed(mdioOut) |-> $fell(mdc);
  endproperty
  a_mdio_edge: assert property (p_mdio_edge) else $error("mdio skew");
  property p_filt_done;
    filtReq.valid |=> filtRsp.done;
  endproperty
  a_filt_done: assert property (p_filt_done) else $error("no verdict");
  property p_filt_kind;
    filtReq.valid |=> filtRsp.multicast == $past(filtReq.destAddr[40]);
  endproperty
  a_filt_kind: assert property (p_filt_kind) else $error("group bit");
  property p_filt_uni;
    filtRsp.done && filtRsp.accept |-> filtRsp.multicast;
  endproperty
  a_filt_uni: assert property (p_filt_uni) else $error("uni pass");
  property p_cfg_hold;
    cfgReq && !cfgAck |=> cfgReq;
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("req drop");
  property p_cfg_step;
    cfgReq && cfgAck && cfgAddr != CFG_ADDR_LAST |=>
      !cfgReq && cfgAddr == $past(cfgAddr) + 8'h01;
  endproperty
  a_cfg_step: assert property (p_cfg_step) else $error("cfg step");
  c_err: cover property (pslverr);
  c_cfg: cover property (cfgReq && cfgAck);
  c_acc: cover property (filtRsp.accept);
endmodule

bind mah_regs_top mah_regs_sva mah_regs_sva_i (.*);

// ---- verif/mah_phy_model.sv ----
// Behavioural PHY management slave with 32 registers
`timescale 1ns/1ps
module mah_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Management pins
  input wire logic mdc,
  input wire logic mdioOut,
  input wire logic mdioOe,
  output logic mdioIn,
  // Last whole frame, first wire bit at the top
  output logic [63:0] lastFrame
);
  logic [15:0] mem [32];
  logic [63:0] frame;
  logic [6:0] bitCnt;
  logic rdOp;
  logic drive;
  logic driveVal;
  logic [15:0] rdVal;
  initial begin
    bitCnt = 7'h00;
    rdOp = 1'b0;
    drive = 1'b0;
    driveVal = 1'b1;
    lastFrame = '0;
    for (int i = 0; i < 32; i++) begin
      mem[i] = 16'h5A00 + 16'(i);
    end
  end
  // Released line floats up through the pull-up
  assign mdioIn = mdioOe ? mdioOut : (drive ? driveVal : 1'b1);
  // Shift in on rising mdc; decode once the header is in
  always @(posedge mdc) begin
    frame = {frame[62:0], mdioIn};
    bitCnt = bitCnt + 7'h01;
    if (bitCnt == 7'd46 && frame[11:10] == 2'b10 &&
        frame[9:5] == PHY_ADDR) begin
      rdOp = 1'b1;
      rdVal = mem[frame[4:0]];
    end
    if (bitCnt == 7'd64) begin
      lastFrame = frame;
      if (frame[29:28] == 2'b01 && frame[27:23] == PHY_ADDR) begin
        mem[frame[22:18]] = frame[15:0];
      end
      bitCnt = 7'h00;
      rdOp = 1'b0;
      drive = 1'b0;
    end
  end
  // Turnaround zero then data, MSB first, set while mdc is low
  always @(negedge mdc) begin
    if (rdOp && bitCnt >= 7'd47) begin
      drive = 1'b1;
      driveVal = (bitCnt == 7'd47) ? 1'b0 : rdVal[7'd63 - bitCnt];
    end
  end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the address, hash and PHY block
`timescale 1ns/1ps
module tb;
  import mah_pkg::*;
  logic clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic cfgPresent, cfgReq, cfgAck, mdc, mdioIn, mdioOut, mdioOe, err;
  logic [7:0] cfgAddr, cfgData;
  logic [63:0] lastFrame;
  mah_filt_req_t filtReq;
  mah_filt_rsp_t filtRsp;
  logic [5:0] tgt [4] = '{6'd0, 6'd31, 6'd32, 6'd63};
  int n_mismatch, cmp_count, cycles;

  mah_regs_top mah_regs_top_i (.*);
  mah_phy_model mah_phy_model_i (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Slow configuration memory; data scrambled once the ack is gone
  initial begin
    cfgAck = 1'b0;
    cfgData = 8'h00;
    forever begin
      @(posedge clk);
      if (cfgReq === 1'b1 && !cfgAck) begin
        repeat (15) @(posedge clk);
        cfgData <= 8'h12 + 8'h22 * (cfgAddr - 8'h01);
        cfgAck <= 1'b1;
        @(posedge clk);
        cfgAck <= 1'b0;
        cfgData <= ~cfgData;
      end
    end
  end
  // Cut a hung run short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e, input string m);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // One APB transfer; request held until ready is seen
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(n), 32'h2, "ready");
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd1(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    rd1(a);
    chk(rd, x, "read");
  endtask
  task automatic setHash(input logic [63:0] t);
    wr(OFS_GROUP_HASH_HIGH, t[63:32]);
    wr(OFS_GROUP_HASH_LOW, t[31:0]);
  endtask
  task automatic filt(input logic [47:0] a, input logic x);
    @(posedge clk);
    filtReq <= '{1'b1, a};
    @(posedge clk);
    filtReq.valid <= 1'b0;
    #1;
    chk(32'(filtRsp.accept), 32'(x), "accept");
    chk(32'(filtRsp.index), 32'(hidx(a)), "index");
  endtask
  // Start a PHY cycle, then poll busy until it drops
  task automatic mgmt(input logic [4:0] p, r, input logic w);
    wr(OFS_PHY_MGMT_ACCESS, {16'h0000, p, r, 4'h0, w, 1'b1});
    rd1(OFS_PHY_MGMT_ACCESS);
    chk(32'(rd[0]), 32'h1, "busy set");
    while (rd[0] !== 1'b0) rd1(OFS_PHY_MGMT_ACCESS);
    chk(32'(rd[0]), 32'h0, "busy clear");
  endtask
  // Index from the group address: CRC, bytes in order, bits LSB first
  function automatic logic [5:0] hidx(input logic [47:0] a);
    logic [31:0] c;
    c = 32'hFFFF_FFFF;
    for (int k = 0; k < 6; k++) begin
      for (int j = 0; j < 8; j++) begin
        c = {c[30:0], 1'b0} ^
          ({32{c[31] ^ a[40 - 8 * k + j]}} & 32'h04C1_1DB7);
      end
    end
    return c[31:26];
  endfunction

  initial begin
    logic [23:0] s;
    logic [47:0] a;
    logic [63:0] m;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    cfgPresent = 1'b0;
    filtReq = '0;
    n_mismatch = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rdc(OFS_STATION_ADDR_LOW, RST_STATION_ADDR_LOW);
    rdc(OFS_GROUP_HASH_HIGH, 32'h0);
    rdc(OFS_GROUP_HASH_LOW, 32'h0);
    rdc(OFS_PHY_MGMT_ACCESS, 32'h0);
    rdc(OFS_FILTER_CTRL, 32'h2);
    wr(OFS_STATION_ADDR_LOW, 32'h9ABC_DEF0);
    rdc(OFS_STATION_ADDR_LOW, 32'h9ABC_DEF0);
    rd1(12'h100);
    chk(32'(err), 32'h1, "unmapped");
    wr(OFS_PHY_MGMT_DATA, 32'hFFFF_FFFF);
    rdc(OFS_PHY_MGMT_DATA, 32'h0000_FFFF);
    wr(OFS_PHY_MGMT_ACCESS, 32'hFFFF_FFFC);
    rdc(OFS_PHY_MGMT_ACCESS, 32'h0000_FFC0);
    setHash(64'hA5A5_0F0F_1234_5678);
    rdc(OFS_GROUP_HASH_HIGH, 32'hA5A5_0F0F);
    rdc(OFS_GROUP_HASH_LOW, 32'h1234_5678);
    $display("test registers done");
    foreach (tgt[k]) begin
      s = 24'h00_0000;
      while (hidx({24'h01_005E, s}) != tgt[k] && s < 24'h00_1388) s++;
      a = {24'h01_005E, s};
      m = '0;
      m[tgt[k]] = 1'b1;
      setHash(m);
      filt(a, 1'b1);
      setHash(~m);
      filt(a, 1'b0);
    end
    wr(OFS_FILTER_CTRL, 32'h1);
    filt(a, 1'b1);
    filt({24'h02_005E, 24'h00_0001}, 1'b0);
    wr(OFS_FILTER_CTRL, 32'h0);
    $display("test hash done");
    wr(OFS_PHY_MGMT_DATA, 32'h0000_BEEF);
    mgmt(5'h01, 5'h05, 1'b1);
    chk(32'(mah_phy_model_i.mem[5]), 32'h0000_BEEF, "phy wr");
    chk(lastFrame[63:32], 32'hFFFF_FFFF, "preamble");
    chk(32'(lastFrame[31:16]), 32'h0000_5096, "header");
    mgmt(5'h01, 5'h09, 1'b0);
    rdc(OFS_PHY_MGMT_DATA, 32'h0000_5A09);
    chk(32'(lastFrame[31:16]), 32'h0000_60A6, "rd header");
    mgmt(5'h03, 5'h09, 1'b0);
    rdc(OFS_PHY_MGMT_DATA, 32'h0000_FFFF);
    $display("test phy done");
    reset <= 1'b1;
    cfgPresent <= 1'b1;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rdc(OFS_FILTER_CTRL, 32'h0);
    wr(OFS_STATION_ADDR_LOW, 32'hAAAA_5555);
    do rd1(OFS_FILTER_CTRL); while (rd[1] !== 1'b1);
    rdc(OFS_STATION_ADDR_LOW, 32'h7856_3412);
    $display("test load done");
    final_report();
  end
endmodule
